// *** include/owt_pkg.sv ***
// ============================================================
// trim loader constants
package owt_pkg;

   // ============================================================
   // word layout
   localparam int WORD_BITS = 37;
   localparam int FUSE_BITS = 31;
   localparam int LAST_BIT = 36;
   localparam int OFS_POS = 0;
   localparam int OFS_W = 10;
   localparam int HALF_POS = 10;
   localparam int CGAIN_POS = 11;
   localparam int CGAIN_W = 3;
   localparam int FGAIN_POS = 14;
   localparam int FGAIN_W = 10;
   localparam int INV_POS = 24;
   localparam int TC_POS = 25;
   localparam int TC_W = 5;
   localparam int SPARE_POS = 30;
   localparam int VOL_POS = 31;
   localparam int VOL_W = 6;
   localparam logic [WORD_BITS-1:0] WORD_RST = 37'h0;
   localparam logic [FUSE_BITS-1:0] FUSE_BLANK = 31'h0;

   // ============================================================
   // timing
   localparam int CLK_MHZ = 100;
   localparam int FAST_RATE_KHZ = 40;
   localparam int SLOW_RATE_KHZ = 4;
   localparam int FAST_SAMPLE_CYC = CLK_MHZ * 1000 / FAST_RATE_KHZ;
   localparam int SLOW_SAMPLE_CYC = CLK_MHZ * 1000 / SLOW_RATE_KHZ;
   localparam int GAP_US = 100;
   localparam int GAP_CYC = GAP_US * CLK_MHZ;
   localparam int BURN_US = 200;
   localparam int BURN_CYC = BURN_US * CLK_MHZ;
   localparam int SAMPLE_DLY_NS = 500;
   localparam logic [7:0] SAMPLE_DLY_RST = 8'(SAMPLE_DLY_NS * CLK_MHZ / 1000);
   localparam int CNT_W = 16;
   localparam int GAIN_STEPS = 7;

   // ============================================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CFG_LO = 8'h08;
   localparam logic [7:0] ADDR_CFG_HI = 8'h0C;
   localparam logic [7:0] ADDR_TEMP_LO = 8'h10;
   localparam logic [7:0] ADDR_TEMP_HI = 8'h14;

   typedef enum logic [3:0] {
      MODE_NORMAL = 4'h1,
      MODE_LOAD = 4'h2,
      MODE_BURN = 4'h4,
      MODE_HOLD = 4'h8
   } owt_mode_t;

endpackage

// *** include/owt_rx_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// link between mode control and bit receiver
interface owt_rx_if;
   logic enable;
   logic [7:0] sample_dly;
   logic [36:0] word;
   logic done;
   logic [5:0] bit_cnt;
   modport rx (input enable, input sample_dly, output word, output done, output bit_cnt);
   modport ctl (output enable, output sample_dly, input word, input done, input bit_cnt);
endinterface
`default_nettype wire

// *** src/owt_bit_rx.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// self-clocked bit receiver
module owt_bit_rx import owt_pkg::*; #(
   parameter int GAP_CYCLES = GAP_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // pin and control
   input wire logic pin_i,
   owt_rx_if.rx rx
);

   typedef struct packed {
      logic pin_d;
      logic busy;
      logic [7:0] cnt;
      logic [CNT_W-1:0] gap;
      logic [5:0] bit_cnt;
      logic [WORD_BITS-1:0] shift;
      logic [WORD_BITS-1:0] word;
      logic done;
   } owt_rx_state_t;

   owt_rx_state_t s;
   owt_rx_state_t next_s;
   logic [WORD_BITS-1:0] shifted;

   always_comb begin
      next_s = s;
      shifted = {s.shift[WORD_BITS-2:0], pin_i};
      next_s.pin_d = pin_i;
      next_s.done = 1'b0;
      if (!rx.enable) begin
         next_s.busy = 1'b0;
         next_s.bit_cnt = 6'h00;
         next_s.gap = '0;
      end else if (!s.busy && pin_i && !s.pin_d) begin
         // each bit opens with a rising edge
         next_s.busy = 1'b1;
         next_s.cnt = 8'h00;
         next_s.gap = '0;
      end else if (s.busy) begin
         next_s.cnt = s.cnt + 8'h01;
         if (s.cnt == rx.sample_dly) begin
            // level a programmable delay (sample_dly) after the edge is the bit value
            next_s.busy = 1'b0;
            next_s.shift = shifted;
            if (s.bit_cnt == 6'(LAST_BIT)) begin
               // full word only, partial words never reach the register
               next_s.word = shifted;
               next_s.done = 1'b1;
               next_s.bit_cnt = 6'h00;
            end else begin
               next_s.bit_cnt = s.bit_cnt + 6'h01;
            end
         end
      end else if (s.bit_cnt != 6'h00) begin
         // a long idle drops a broken word so the next one starts clean
         next_s.gap = s.gap + 16'h0001;
         if (s.gap == CNT_W'(GAP_CYCLES - 1)) begin
            next_s.bit_cnt = 6'h00;
            next_s.gap = '0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rx.word = s.word;
   assign rx.done = s.done;
   assign rx.bit_cnt = s.bit_cnt;

   // ============================================================
   // checks
   bit_count_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s.done |-> $past(s.bit_cnt) == 6'(LAST_BIT) && s.bit_cnt == 6'h00)
      else $error("word closed at wrong bit count");

   edge_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rx.enable && !s.busy && pin_i && !s.pin_d) |=> s.busy && s.cnt == 8'h00 ##[1:256] !s.busy)
      else $error("rising edge did not start a bit");

endmodule
`default_nettype wire

// *** src/owt_loader.sv ***
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - load supply level turns pin into input
// - load mode accepts full 37-bit words
// - self-clocked bits sampled a programmable delay (sample_dly) after rising edges
// - received word applies to settings at once
// - repeated words replace the temporary register
// - burn supply fixes 31 fuses from temp
// - burn happens once, fuses never change after
// - 10-bit quiescent offset code, 1024 levels
// - half supply bit selects narrow offset range
// - sample rate 4 to 40 kHz by coarse gain
// - 3-bit coarse and 10-bit fine gain
// - slope invert bit reverses field polarity
// - 5-bit drift compensation code, default zero

// ============================================================
// trim loader top
module owt_loader import owt_pkg::*; #(
   parameter int GAP_CYCLES = GAP_CYC,
   parameter int BURN_CYCLES = BURN_CYC,
   parameter int SLOW_SAMPLE_CYCLES = SLOW_SAMPLE_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // supply level detectors
   input wire logic supply_load_i,
   input wire logic supply_burn_i,
   // shared output pin
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   // fuse array
   input wire logic [FUSE_BITS-1:0] fuse_i,
   output logic burn_en_o,
   output logic [FUSE_BITS-1:0] burn_data_o,
   // working settings to the signal chain
   output logic [OFS_W-1:0] quiescent_offset_code_o,
   output logic half_supply_range_select_o,
   output logic [CGAIN_W-1:0] coarse_gain_code_o,
   output logic [FGAIN_W-1:0] fine_gain_code_o,
   output logic slope_invert_bit_o,
   output logic [TC_W-1:0] temp_drift_comp_code_o,
   output logic spare_fused_o,
   output logic [VOL_W-1:0] volatile_bits_o,
   output logic sample_tick_o,
   // apb slave
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);

   localparam int GAIN_STEP = (SLOW_SAMPLE_CYCLES - FAST_SAMPLE_CYC) / GAIN_STEPS;

   typedef struct packed {
      owt_mode_t mode;
      logic [WORD_BITS-1:0] temp;
      logic temp_valid;
      logic [WORD_BITS-1:0] work;
      logic [7:0] word_cnt;
      logic [CNT_W-1:0] burn_cnt;
      logic burn_en;
      logic [FUSE_BITS-1:0] burn_data;
      logic burned;
      logic [CNT_W-1:0] samp_cnt;
      logic sample_tick;
      logic pin_oe;
      logic [7:0] sample_dly;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } owt_top_state_t;

   owt_top_state_t s;
   owt_top_state_t next_s;
   owt_rx_if rx_if ();

   logic [CNT_W-1:0] samp_period;
   logic [31:0] rd_data;
   logic rd_hit;
   logic apb_done;

   // ============================================================
   // bit receiver
   owt_bit_rx #(
      .GAP_CYCLES(GAP_CYCLES)
   ) u_rx (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .pin_i(pin_i),
      .rx(rx_if.rx)
   );

   assign rx_if.enable = (s.mode == MODE_LOAD);
   assign rx_if.sample_dly = s.sample_dly;

   // ============================================================
   // register read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (paddr_i)
         ADDR_CTRL: rd_data = {24'h00_0000, s.sample_dly};
         ADDR_STATUS: rd_data = {10'h000, rx_if.bit_cnt, s.word_cnt, 2'h0, s.burned, s.temp_valid, s.mode};
         ADDR_CFG_LO: rd_data = s.work[31:0];
         ADDR_CFG_HI: rd_data = {27'h000_0000, s.work[WORD_BITS-1:32]};
         ADDR_TEMP_LO: rd_data = s.temp[31:0];
         ADDR_TEMP_HI: rd_data = {27'h000_0000, s.temp[WORD_BITS-1:32]};
         default: rd_hit = 1'b0;
      endcase
   end

   assign apb_done = psel_i && penable_i && s.pready;

   // ============================================================
   // next state
   always_comb begin
      next_s = s;
      next_s.sample_tick = 1'b0;
      samp_period = CNT_W'(FAST_SAMPLE_CYC) + CNT_W'(s.work[CGAIN_POS +: CGAIN_W]) * CNT_W'(GAIN_STEP);

      // apb: one wait state, registered answer
      next_s.pready = psel_i && penable_i && !s.pready;
      if (psel_i && penable_i && !s.pready) begin
         next_s.prdata = pwrite_i ? 32'h0000_0000 : rd_data;
         next_s.pslverr = !rd_hit;
      end else begin
         next_s.prdata = 32'h0000_0000;
         next_s.pslverr = 1'b0;
      end
      if (apb_done && pwrite_i && paddr_i == ADDR_CTRL) begin
         next_s.sample_dly = pwdata_i[7:0];
      end

      // word capture into the volatile register
      if (rx_if.done) begin
         next_s.temp = rx_if.word;
         next_s.temp_valid = 1'b1;
         next_s.word_cnt = s.word_cnt + 8'h01;
      end

      // mode decode from supply comparators
      unique case (s.mode)
         MODE_NORMAL: begin
            if (supply_burn_i) begin
               next_s.mode = MODE_BURN;
            end else if (supply_load_i) begin
               next_s.mode = MODE_LOAD;
            end
         end
         MODE_LOAD: begin
            if (supply_burn_i) begin
               next_s.mode = MODE_BURN;
            end else if (!supply_load_i) begin
               next_s.mode = MODE_NORMAL;
            end
         end
         MODE_BURN: begin
            if (!s.burn_en) begin
               // blank array and a loaded word are both needed
               if (fuse_i == FUSE_BLANK && s.temp_valid) begin
                  next_s.burn_en = 1'b1;
                  next_s.burn_data = s.temp[FUSE_BITS-1:0];
                  next_s.burn_cnt = '0;
               end else begin
                  next_s.mode = MODE_HOLD;
               end
            end else begin
               // pulse runs to full length even if supply sags
               next_s.burn_cnt = s.burn_cnt + 16'h0001;
               if (s.burn_cnt == CNT_W'(BURN_CYCLES - 1)) begin
                  next_s.burn_en = 1'b0;
                  next_s.burned = 1'b1;
                  next_s.mode = MODE_HOLD;
               end
            end
         end
         MODE_HOLD: begin
            // wait out the high supply so one excursion burns once
            if (!supply_burn_i) begin
               next_s.mode = supply_load_i ? MODE_LOAD : MODE_NORMAL;
            end
         end
      endcase
      next_s.pin_oe = (next_s.mode == MODE_NORMAL);

      // working settings: loaded word wins, else the fuses
      if (s.temp_valid) begin
         next_s.work = s.temp;
      end else begin
         next_s.work = {{VOL_W{1'b0}}, fuse_i};
      end

      // sample clock divider
      if (s.samp_cnt >= samp_period - 16'h0001) begin
         next_s.samp_cnt = '0;
         next_s.sample_tick = 1'b1;
      end else begin
         next_s.samp_cnt = s.samp_cnt + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s <= '{
            mode: MODE_NORMAL,
            temp: WORD_RST,
            temp_valid: 1'b0,
            work: WORD_RST,
            word_cnt: 8'h00,
            burn_cnt: 16'h0000,
            burn_en: 1'b0,
            burn_data: FUSE_BLANK,
            burned: 1'b0,
            samp_cnt: 16'h0000,
            sample_tick: 1'b0,
            pin_oe: 1'b1,
            sample_dly: SAMPLE_DLY_RST,
            prdata: 32'h0000_0000,
            pready: 1'b0,
            pslverr: 1'b0
         };
      end else begin
         s <= next_s;
      end
   end

   // ============================================================
   // outputs
   assign pin_o = 1'b0;
   assign pin_oe_o = s.pin_oe;
   assign burn_en_o = s.burn_en;
   assign burn_data_o = s.burn_data;
   assign quiescent_offset_code_o = s.work[OFS_POS +: OFS_W];
   assign half_supply_range_select_o = s.work[HALF_POS];
   assign coarse_gain_code_o = s.work[CGAIN_POS +: CGAIN_W];
   assign fine_gain_code_o = s.work[FGAIN_POS +: FGAIN_W];
   assign slope_invert_bit_o = s.work[INV_POS];
   assign temp_drift_comp_code_o = s.work[TC_POS +: TC_W];
   assign spare_fused_o = s.work[SPARE_POS];
   assign volatile_bits_o = s.work[VOL_POS +: VOL_W];
   assign sample_tick_o = s.sample_tick;
   assign prdata_o = s.prdata;
   assign pready_o = s.pready;
   assign pslverr_o = s.pslverr;

   // ============================================================
   // checks
   int unsigned tick_gap;
   logic tick_seen;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tick_gap <= 0;
         tick_seen <= 1'b0;
      end else if (sample_tick_o) begin
         tick_gap <= 1;
         tick_seen <= 1'b1;
      end else begin
         tick_gap <= tick_gap + 1;
      end
   end

   pin_dir_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (s.mode == MODE_NORMAL && supply_load_i && !supply_burn_i) |=> !pin_oe_o)
      else $error("pin still driving in load mode");

   word_take_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      rx_if.done |=> s.temp == $past(rx_if.word) && s.word_cnt == $past(s.word_cnt) + 8'h01)
      else $error("received word not taken");

   cfg_apply_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (rx_if.done ##1 !rx_if.done) |=> quiescent_offset_code_o == s.temp[OFS_POS +: OFS_W]
         && slope_invert_bit_o == s.temp[INV_POS] && temp_drift_comp_code_o == s.temp[TC_POS +: TC_W]
         && fine_gain_code_o == s.temp[FGAIN_POS +: FGAIN_W])
      else $error("loaded word not applied");

   burn_once_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(burn_en_o) |-> $past(fuse_i) == FUSE_BLANK && !$past(s.burned))
      else $error("burn started on used fuses");

   burn_data_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      burn_en_o |-> burn_data_o == s.temp[FUSE_BITS-1:0] && s.mode == MODE_BURN)
      else $error("burn data differs from temporary word");

   fuse_boot_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (!rst_i && !s.temp_valid && $stable(fuse_i)) |=> quiescent_offset_code_o == fuse_i[OFS_POS +: OFS_W]
         && volatile_bits_o == 6'h00)
      else $error("settings not taken from fuses");

   tick_rate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (sample_tick_o && tick_seen && $stable(coarse_gain_code_o)) |->
         tick_gap >= FAST_SAMPLE_CYC && tick_gap <= SLOW_SAMPLE_CYCLES)
      else $error("sample rate out of range");

endmodule
`default_nettype wire

// *** tb/owt_prog_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// programmer: supply levels, self-clocked pin, fuse array
module owt_prog_model import owt_pkg::*; (
   // clock
   input wire logic ref_clk_i,
   // burn request from the device
   input wire logic burn_en_i,
   input wire logic [FUSE_BITS-1:0] burn_data_i,
   // pin, supply and fuses toward the device
   output logic pin_o,
   output logic supply_load_o,
   output logic supply_burn_o,
   output logic [FUSE_BITS-1:0] fuse_o
);
   initial begin
      pin_o = 1'b0;
      supply_load_o = 1'b0;
      supply_burn_o = 1'b0;
      fuse_o = FUSE_BLANK;
   end

   // a blown fuse never returns to zero
   always @(posedge ref_clk_i) begin
      if (burn_en_i) begin
         fuse_o <= fuse_o | burn_data_i;
      end
   end

   task automatic set_supply(input logic ld, input logic bn);
      @(posedge ref_clk_i);
      supply_load_o <= ld;
      supply_burn_o <= bn;
   endtask

   // rise marks the bit, level held well past the sample point is its value
   task automatic send_bits(input logic [WORD_BITS-1:0] w, input int n);
      for (int i = LAST_BIT; i > LAST_BIT - n; i--) begin
         @(posedge ref_clk_i);
         pin_o <= 1'b1;
         repeat (10) @(posedge ref_clk_i);
         pin_o <= w[i];
         repeat (60) @(posedge ref_clk_i);
         pin_o <= 1'b0;
         repeat (10) @(posedge ref_clk_i);
      end
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
// ============================================================
// trim loader bench
module tb import owt_pkg::*; ;
   localparam int GAP = 200;
   localparam int BURN = 20;
   localparam int SLOW = 2507;
   localparam logic [WORD_BITS-1:0] W1 = 37'h0A3C5A4213;
   localparam logic [WORD_BITS-1:0] W2 = 37'h1A5555F8A3;
   int err_count = 0;
   int total_checks = 0;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic prog_pin, ld, bn, pin_o, pin_oe, burn_en, half, inv, spare, tick;
   logic [FUSE_BITS-1:0] fuse, burn_data;
   logic [OFS_W-1:0] ofs;
   logic [CGAIN_W-1:0] cg;
   logic [FGAIN_W-1:0] fg;
   logic [TC_W-1:0] tc;
   logic [VOL_W-1:0] vol;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   wire logic pin_w;
   wire logic [WORD_BITS-1:0] sett;
   // device owns the pin in normal mode only
   assign pin_w = pin_oe ? pin_o : prog_pin;
   assign sett = {vol, spare, tc, inv, fg, cg, half, ofs};

   owt_prog_model u_prog (.ref_clk_i(ref_clk), .burn_en_i(burn_en), .burn_data_i(burn_data),
      .pin_o(prog_pin), .supply_load_o(ld), .supply_burn_o(bn), .fuse_o(fuse));
   owt_loader #(.GAP_CYCLES(GAP), .BURN_CYCLES(BURN), .SLOW_SAMPLE_CYCLES(SLOW)) u_dut (
      .ref_clk_i(ref_clk), .rst_i(rst), .supply_load_i(ld), .supply_burn_i(bn), .pin_i(pin_w),
      .pin_o(pin_o), .pin_oe_o(pin_oe), .fuse_i(fuse), .burn_en_o(burn_en), .burn_data_o(burn_data),
      .quiescent_offset_code_o(ofs), .half_supply_range_select_o(half), .coarse_gain_code_o(cg),
      .fine_gain_code_o(fg), .slope_invert_bit_o(inv), .temp_drift_comp_code_o(tc),
      .spare_fused_o(spare), .volatile_bits_o(vol), .sample_tick_o(tick), .paddr_i(paddr),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // ============================================================
   // bus and helpers
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      `CHK("prdata", x, r)
      `CHK("pslverr", xe, e)
   endtask

   // second interval only: the first may still run on the old gain
   task automatic t_rate(input logic [WORD_BITS-1:0] w);
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (tick !== 1'b1 && n < 30000);
      end
      `CHK("tick period", 2500 + int'(w[13:11]) * ((SLOW - 2500) / 7), n)
   endtask

   task automatic end_of_test();
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ============================================================
   // scenarios
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      repeat (3) @(posedge ref_clk);
      `CHK("pin_oe", 1'b1, pin_oe)
      `CHK("pin level", 1'b0, pin_o)
      `CHK("settings", {6'h0, fuse}, sett)
      rd(ADDR_STATUS, 32'h1, 1'b0);
      rd(ADDR_CTRL, {24'h0, SAMPLE_DLY_RST}, 1'b0);
      apb(ADDR_STATUS, 1'b1, 32'hFFFFFFFF, r, e);
      `CHK("pslverr", 1'b0, e)
      rd(ADDR_STATUS, 32'h1, 1'b0);
      // shorter sample delay still lands inside the programmer's data window
      apb(ADDR_CTRL, 1'b1, 32'h0000_0028, r, e);
      `CHK("pslverr", 1'b0, e)
      rd(ADDR_CTRL, 32'h0000_0028, 1'b0);
      rd(8'h18, 32'h0, 1'b1);
   endtask

   task automatic t_load();
      u_prog.set_supply(1'b1, 1'b0);
      repeat (4) @(posedge ref_clk);
      `CHK("pin_oe", 1'b0, pin_oe)
      rd(ADDR_STATUS, 32'h2, 1'b0);
      u_prog.send_bits(W1, WORD_BITS);
      repeat (5) @(posedge ref_clk);
      `CHK("settings", W1, sett)
      rd(ADDR_CFG_LO, W1[31:0], 1'b0);
      rd(ADDR_TEMP_HI, {27'h0, W1[36:32]}, 1'b0);
      t_rate(W1);
   endtask

   // a stalled partial word is dropped, then a full one replaces the first
   task automatic t_reload();
      u_prog.send_bits(W2, 20);
      repeat (GAP + 50) @(posedge ref_clk);
      `CHK("settings", W1, sett)
      u_prog.send_bits(W2, WORD_BITS);
      repeat (5) @(posedge ref_clk);
      `CHK("settings", W2, sett)
      t_rate(W2);
   endtask

   task automatic t_burn();
      int n;
      u_prog.set_supply(1'b1, 1'b1);
      n = 0;
      while (burn_en !== 1'b1 && n < 10) begin
         @(posedge ref_clk);
         n++;
      end
      `CHK("burn data", W2[30:0], burn_data)
      n = 0;
      while (burn_en === 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      `CHK("burn length", BURN, n)
      u_prog.set_supply(1'b1, 1'b0);
      repeat (4) @(posedge ref_clk);
      `CHK("fuses", W2[30:0], fuse)
      // load mode again, loaded and burned set, two full words counted
      rd(ADDR_STATUS, 32'h0000_0232, 1'b0);
      u_prog.set_supply(1'b1, 1'b1);
      n = 0;
      repeat (40) begin
         @(posedge ref_clk);
         if (burn_en === 1'b1) begin
            n++;
         end
      end
      `CHK("second burn", 0, n)
      u_prog.set_supply(1'b0, 1'b0);
      repeat (4) @(posedge ref_clk);
      `CHK("settings", W2, sett)
      rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      `CHK("settings", {6'h0, W2[30:0]}, sett)
   endtask

   // ============================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_load();
      t_reload();
      t_burn();
      end_of_test();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      err_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
